// File: design/event_timer_defines.vh
/*
  shared sizes, field codes and reset values of the event timer.
  assumes inclusion by bare name from every design file that needs it.
*/
`ifndef EVENT_TIMER_DEFINES_VH
`define EVENT_TIMER_DEFINES_VH

// ----------------------------------------
// sizes
// ----------------------------------------
`define EV_N 10
`define ST_N 10
`define IN_N 8
`define OUT_N 8
`define MR_N 10
`define HALF_W 16
`define CNT_W 32

// ----------------------------------------
// field widths of per-event config slices
// ----------------------------------------
`define SEL_W 4
`define ST_W 4
`define COND_W 2
`define COMB_W 2
`define DIRQ_W 2

// ----------------------------------------
// io condition codes
// ----------------------------------------
`define COND_LOW 2'h0
`define COND_RISE 2'h1
`define COND_FALL 2'h2
`define COND_HIGH 2'h3

// ----------------------------------------
// combine codes
// ----------------------------------------
`define COMB_OR 2'h0
`define COMB_MATCH 2'h1
`define COMB_IO 2'h2
`define COMB_AND 2'h3

// ----------------------------------------
// direction qualifier codes
// ----------------------------------------
`define DIRQ_ANY 2'h0
`define DIRQ_UP 2'h1
`define DIRQ_DOWN 2'h2

// ----------------------------------------
// reset values and half count maximum
// ----------------------------------------
`define CNT_RST 16'h0000
`define STATE_RST 4'h0
`define OUT_RST 8'h00
`define CAP_RST 32'h00000000
`define HALF_MAX 16'hffff

`endif

// File: design/count_half.v
/*
  one 16-bit half of the event timer counter with limit and reversal.
  assumes the top gates tick, limit and zero reversal for unified mode.
*/
`timescale 1ns/1ps
`include "event_timer_defines.vh"

module count_half
(
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // control
  input wire tick,
  input wire limit,
  input wire rev_zero,
  input wire bidir,
  // state
  output wire [`HALF_W-1:0] count,
  output wire dir_down
);

reg [`HALF_W-1:0] cnt_reg;
reg dir_reg;

// ----------------------------------------
// count, clear or reverse on limit, turn up at zero
// ----------------------------------------
always @(posedge ref_clk)
begin
  if (!rst_b)
  begin
    cnt_reg <= `CNT_RST;
    dir_reg <= 1'b0;
  end
  else if (limit)
  begin
    if (bidir)
      dir_reg <= ~dir_reg;
    else
      cnt_reg <= `CNT_RST;
  end
  else if (rev_zero)
    dir_reg <= 1'b0; // bottom of bidir sweep
  else if (tick)
  begin
    if (dir_reg)
      cnt_reg <= cnt_reg - 16'h0001;
    else
      cnt_reg <= cnt_reg + 16'h0001;
  end
end

assign count = cnt_reg;
assign dir_down = dir_reg;

endmodule // count_half

// File: design/event_unit.v
/*
  one event: io edge or level test, combine with match, direction and
  state qualifiers, and a pending latch for held matches.
  assumes match_hit is a one-cycle pulse on a counting tick.
*/
`timescale 1ns/1ps
`include "event_timer_defines.vh"

module event_unit
(
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // qualifiers
  input wire match_hit,
  input wire io_now,
  input wire io_prev,
  input wire [`COND_W-1:0] io_cond,
  input wire [`COMB_W-1:0] comb,
  input wire [`DIRQ_W-1:0] dir_qual,
  input wire bidir,
  input wire dir_down,
  input wire hold_en,
  input wire state_ok,
  // result
  output wire fire
);

reg pend_reg;
reg pend_next;
reg io_ok;
reg comb_ok;
reg dir_ok;
wire m_ok;

// ----------------------------------------
// io condition and combination
// ----------------------------------------
assign m_ok = match_hit | pend_reg;

always @*
begin
  case (io_cond)
    `COND_LOW: io_ok = ~io_now;
    `COND_RISE: io_ok = io_now & ~io_prev;
    `COND_FALL: io_ok = ~io_now & io_prev;
    default: io_ok = io_now;
  endcase
  case (comb)
    `COMB_OR: comb_ok = m_ok | io_ok;
    `COMB_MATCH: comb_ok = m_ok;
    `COMB_IO: comb_ok = io_ok;
    default: comb_ok = m_ok & io_ok;
  endcase
  case (dir_qual)
    `DIRQ_UP: dir_ok = ~bidir | ~dir_down;
    `DIRQ_DOWN: dir_ok = ~bidir | dir_down;
    default: dir_ok = 1'b1;
  endcase
end

assign fire = state_ok & dir_ok & comb_ok;

// ----------------------------------------
// held match waits for the io part
// ----------------------------------------
always @*
begin
  pend_next = pend_reg;
  if (fire)
    pend_next = 1'b0;
  if (hold_en & match_hit & state_ok & ~fire)
    pend_next = 1'b1;
end

always @(posedge ref_clk)
begin
  if (!rst_b)
    pend_reg <= 1'b0;
  else
    pend_reg <= pend_next;
end

endmodule // event_unit

// File: design/event_state_timer_pwm.v
/*
  event driven timer and waveform block: one 32-bit or two 16-bit
  counters, ten match/capture registers, ten events, ten states,
  eight inputs and eight outputs.
  assumes all config ports are static while running and pins are
  synchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "event_timer_defines.vh"

module event_state_timer_pwm
(
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // pins
  input wire [`IN_N-1:0] in_pins,
  output wire [`OUT_N-1:0] out_pins,
  // counter configuration
  input wire unify,
  input wire bidir_l,
  input wire bidir_h,
  input wire auto_limit_l,
  input wire auto_limit_h,
  input wire clk_mode,
  input wire [2:0] clk_in_sel,
  input wire clk_edge,
  input wire halt_release_l,
  input wire halt_release_h,
  // match and capture configuration
  input wire [`MR_N*`CNT_W-1:0] match_val,
  input wire [`MR_N-1:0] cap_mode,
  // event qualifiers
  input wire [`EV_N*`ST_N-1:0] ev_state_mask,
  input wire [`EV_N*`SEL_W-1:0] ev_match_sel,
  input wire [`EV_N*`SEL_W-1:0] ev_io_sel,
  input wire [`EV_N*`COND_W-1:0] ev_io_cond,
  input wire [`EV_N*`COMB_W-1:0] ev_comb,
  input wire [`EV_N*`DIRQ_W-1:0] ev_dir,
  input wire [`EV_N-1:0] ev_ctr_h,
  input wire [`EV_N-1:0] ev_hold,
  // event actions
  input wire [`EV_N-1:0] ev_start,
  input wire [`EV_N-1:0] ev_stop,
  input wire [`EV_N-1:0] ev_halt,
  input wire [`EV_N-1:0] ev_limit,
  input wire [`EV_N*`OUT_N-1:0] ev_out_set,
  input wire [`EV_N*`OUT_N-1:0] ev_out_clr,
  input wire [`EV_N*`MR_N-1:0] ev_cap,
  input wire [`EV_N*`ST_W-1:0] ev_next_state,
  input wire [`EV_N-1:0] ev_state_ld,
  input wire [`EV_N-1:0] ev_irq,
  input wire [`EV_N-1:0] ev_dma,
  // status
  output wire [`CNT_W-1:0] count_val,
  output wire [`MR_N*`CNT_W-1:0] cap_val,
  output wire [`ST_W-1:0] state_val,
  output wire [`EV_N-1:0] ev_fired,
  output wire irq_req,
  output wire dma_req,
  output wire run_l,
  output wire run_h,
  output wire dir_down_l,
  output wire dir_down_h
);

// ----------------------------------------
// helpers
// ----------------------------------------
// bit of {outputs, inputs}: index 0-7 inputs, 8-15 outputs
function pick16;
  input [15:0] vec;
  input [3:0] idx;
  begin
    pick16 = vec[idx];
  end
endfunction

// bit of a ten-wide mask, zero past the end
function pick10;
  input [9:0] vec;
  input [3:0] idx;
  begin
    pick10 = (idx < 4'ha) ? vec[idx] : 1'b0;
  end
endfunction

// ----------------------------------------
// registers and wires
// ----------------------------------------
reg [`IN_N-1:0] in_prev_reg;
reg [`OUT_N-1:0] out_reg, out_next, out_prev_reg;
reg [`ST_W-1:0] state_reg, state_next;
reg run_l_reg, run_h_reg, halt_l_reg, halt_h_reg;
reg [`EV_N-1:0] fired_reg;
reg irq_reg, dma_reg, set_b, clr_b;
reg [`CNT_W-1:0] cap_mem [0:`MR_N-1];
integer i, j, m;

wire [`EV_N-1:0] fire;
wire [`HALF_W-1:0] count_l, count_h;
wire [`CNT_W-1:0] count_all;
wire dir_l, dir_h, sel_now, sel_prev, tick_src, tick_l, tick_h, wrap_l;
wire bidir_eff_h, rev_zero_l, rev_zero_h;
wire [`MR_N-1:0] hit_l, hit_h;
wire [`EV_N-1:0] side_h;
wire limit_l_ev, limit_h_ev, limit_l, limit_h;
wire [15:0] io_now_vec, io_prev_vec;

assign count_all = {count_h, count_l};
assign io_now_vec = {out_reg, in_pins};
assign io_prev_vec = {out_prev_reg, in_prev_reg};

// ----------------------------------------
// count clock: system clock or input edge
// ----------------------------------------
assign sel_now = pick16(io_now_vec, {1'b0, clk_in_sel});
assign sel_prev = pick16(io_prev_vec, {1'b0, clk_in_sel});
assign tick_src = ~clk_mode | (clk_edge ? (sel_prev & ~sel_now)
                                        : (~sel_prev & sel_now));

// ----------------------------------------
// counter chaining for unified mode
// ----------------------------------------
assign tick_l = run_l_reg & tick_src;
assign wrap_l = dir_l ? (count_l == `CNT_RST) : (count_l == `HALF_MAX);
assign bidir_eff_h = unify ? bidir_l : bidir_h;
assign rev_zero_l = bidir_l & dir_l & tick_l &
                    (unify ? (count_all == `CAP_RST) : (count_l == `CNT_RST));
assign rev_zero_h = unify ? rev_zero_l
                          : (bidir_h & dir_h & tick_h & (count_h == `CNT_RST));
assign tick_h = unify ? (tick_l & wrap_l & ~rev_zero_l)
                      : (run_h_reg & tick_src);

// ----------------------------------------
// match detection per register and half
// ----------------------------------------
genvar g;
generate
  for (g = 0; g < `MR_N; g = g + 1)
  begin : g_match
    wire [`CNT_W-1:0] mv;
    assign mv = match_val[g*`CNT_W +: `CNT_W];
    assign hit_l[g] = ~cap_mode[g] & tick_l &
                      (unify ? (count_all == mv) : (count_l == mv[15:0]));
    assign hit_h[g] = ~cap_mode[g] & ~unify & tick_h & (count_h == mv[31:16]);
    assign cap_val[g*`CNT_W +: `CNT_W] = cap_mem[g];
  end
endgenerate

// ----------------------------------------
// events
// ----------------------------------------
generate
  for (g = 0; g < `EV_N; g = g + 1)
  begin : g_event
    wire [`SEL_W-1:0] msel;
    wire [`SEL_W-1:0] isel;
    wire m_hit;
    assign side_h[g] = ev_ctr_h[g] & ~unify;
    assign msel = ev_match_sel[g*`SEL_W +: `SEL_W];
    assign isel = ev_io_sel[g*`SEL_W +: `SEL_W];
    assign m_hit = side_h[g] ? pick10(hit_h, msel) : pick10(hit_l, msel);
    event_unit u_ev
    (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .match_hit(m_hit),
      .io_now(pick16(io_now_vec, isel)),
      .io_prev(pick16(io_prev_vec, isel)),
      .io_cond(ev_io_cond[g*`COND_W +: `COND_W]),
      .comb(ev_comb[g*`COMB_W +: `COMB_W]),
      .dir_qual(ev_dir[g*`DIRQ_W +: `DIRQ_W]),
      .bidir(side_h[g] ? bidir_h : bidir_l),
      .dir_down(side_h[g] ? dir_h : dir_l),
      .hold_en(ev_hold[g]),
      .state_ok(pick10(ev_state_mask[g*`ST_N +: `ST_N], state_reg)),
      .fire(fire[g])
    );
  end
endgenerate

// ----------------------------------------
// limit: events and automatic match 0
// ----------------------------------------
assign limit_l_ev = |(fire & ev_limit & ~side_h);
assign limit_h_ev = |(fire & ev_limit & side_h);
// up/down: auto limit only on the way up, else the down pass turns it back
assign limit_l = limit_l_ev | (auto_limit_l & hit_l[0] & ~(bidir_l & dir_l));
assign limit_h = unify ? limit_l
                       : (limit_h_ev | (auto_limit_h & hit_h[0] & ~(bidir_h & dir_h)));

count_half u_cnt_l
(
  .ref_clk(ref_clk),
  .rst_b(rst_b),
  .tick(tick_l),
  .limit(limit_l),
  .rev_zero(rev_zero_l),
  .bidir(bidir_l),
  .count(count_l),
  .dir_down(dir_l)
);

count_half u_cnt_h
(
  .ref_clk(ref_clk),
  .rst_b(rst_b),
  .tick(tick_h),
  .limit(limit_h),
  .rev_zero(rev_zero_h),
  .bidir(bidir_eff_h),
  .count(count_h),
  .dir_down(dir_h)
);

// ----------------------------------------
// run control: start, stop, halt
// ----------------------------------------
always @(posedge ref_clk)
begin
  if (!rst_b)
  begin
    run_l_reg <= 1'b0;
    run_h_reg <= 1'b0;
    halt_l_reg <= 1'b1;
    halt_h_reg <= 1'b1;
  end
  else
  begin
    if (|(fire & ev_halt & ~side_h))
    begin
      halt_l_reg <= 1'b1;
      run_l_reg <= 1'b0;
    end
    else if (halt_release_l)
    begin
      halt_l_reg <= 1'b0;
      run_l_reg <= 1'b1;
    end
    else if (|(fire & ev_stop & ~side_h))
      run_l_reg <= 1'b0;
    else if (|(fire & ev_start & ~side_h) & ~halt_l_reg)
      run_l_reg <= 1'b1;
    if (|(fire & ev_halt & side_h))
    begin
      halt_h_reg <= 1'b1;
      run_h_reg <= 1'b0;
    end
    else if (halt_release_h)
    begin
      halt_h_reg <= 1'b0;
      run_h_reg <= 1'b1;
    end
    else if (|(fire & ev_stop & side_h))
      run_h_reg <= 1'b0;
    else if (|(fire & ev_start & side_h) & ~halt_h_reg)
      run_h_reg <= 1'b1;
  end
end

// ----------------------------------------
// outputs and state from fired events
// ----------------------------------------
always @*
begin
  out_next = out_reg;
  state_next = state_reg;
  set_b = 1'b0;
  clr_b = 1'b0;
  for (j = 0; j < `OUT_N; j = j + 1)
  begin
    set_b = 1'b0;
    clr_b = 1'b0;
    for (i = 0; i < `EV_N; i = i + 1)
    begin
      set_b = set_b | (fire[i] & ev_out_set[i*`OUT_N + j]);
      clr_b = clr_b | (fire[i] & ev_out_clr[i*`OUT_N + j]);
    end
    if (set_b & clr_b)
      out_next[j] = ~out_reg[j];
    else if (set_b)
      out_next[j] = 1'b1;
    else if (clr_b)
      out_next[j] = 1'b0;
  end
  // lowest numbered loading event wins
  for (i = `EV_N - 1; i >= 0; i = i - 1)
  begin
    if (fire[i] & ev_state_ld[i] & (ev_next_state[i*`ST_W +: `ST_W] < 4'ha))
      state_next = ev_next_state[i*`ST_W +: `ST_W];
  end
end

always @(posedge ref_clk)
begin
  if (!rst_b)
  begin
    out_reg <= `OUT_RST;
    out_prev_reg <= `OUT_RST;
    in_prev_reg <= 8'h00;
    state_reg <= `STATE_RST;
    fired_reg <= 10'h000;
    irq_reg <= 1'b0;
    dma_reg <= 1'b0;
  end
  else
  begin
    out_reg <= out_next;
    out_prev_reg <= out_reg;
    in_prev_reg <= in_pins;
    state_reg <= state_next;
    fired_reg <= fire;
    irq_reg <= |(fire & ev_irq);
    dma_reg <= |(fire & ev_dma);
  end
end

// ----------------------------------------
// capture of the count
// ----------------------------------------
always @(posedge ref_clk)
begin
  for (m = 0; m < `MR_N; m = m + 1)
  begin
    if (!rst_b)
      cap_mem[m] <= `CAP_RST;
    else if (cap_mode[m] & |(fire & ev_cap_col(m)))
      cap_mem[m] <= count_all;
  end
end

// column j of the per-event capture masks
function [`EV_N-1:0] ev_cap_col;
  input integer col;
  integer k;
  begin
    ev_cap_col = 10'h000;
    for (k = 0; k < `EV_N; k = k + 1)
      ev_cap_col[k] = ev_cap[k*`MR_N + col];
  end
endfunction

// ----------------------------------------
// status
// ----------------------------------------
assign out_pins = out_reg;
assign count_val = count_all;
assign state_val = state_reg;
assign ev_fired = fired_reg;
assign irq_req = irq_reg;
assign dma_req = dma_reg;
assign run_l = run_l_reg;
assign run_h = run_h_reg;
assign dir_down_l = dir_l;
assign dir_down_h = dir_h;

endmodule // event_state_timer_pwm

// File: dv/input_pins_model.sv
/*
  model of the external input pins that feed the event timer.
  assumes the bench calls its tasks just after a rising edge.
*/
`timescale 1ns/1ps
`include "event_timer_defines.vh"

module input_pins_model
(
  // clock
  input wire ref_clk,
  // pins toward the block
  output wire [`IN_N-1:0] pins
);
  reg [`IN_N-1:0] pins_reg = 8'h00;

  // pins are plain synchronous levels, never released
  assign pins = pins_reg;

  // drive one pin level
  task set_pin(input integer idx, input logic val);
    pins_reg[idx] = val;
  endtask

  // clock pulses on one pin, two cycles high and two low
  task pulse(input integer idx, input integer n);
    integer k;
    for (k = 0; k < n; k = k + 1)
    begin
      pins_reg[idx] = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      pins_reg[idx] = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
    end
  endtask
endmodule // input_pins_model

// File: dv/event_timer_monitor.sv
/*
  concurrent checks on the event timer top ports.
  assumes config only changes while reset is low; bound below.
*/
`timescale 1ns/1ps
`include "event_timer_defines.vh"

module event_timer_monitor
(
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // configuration
  input wire unify,
  input wire bidir_l,
  input wire auto_limit_l,
  input wire clk_mode,
  input wire [`MR_N-1:0] cap_mode,
  input wire [`MR_N*`CNT_W-1:0] match_val,
  input wire [`EV_N*`ST_N-1:0] ev_state_mask,
  input wire [`EV_N-1:0] ev_stop,
  input wire [`EV_N-1:0] ev_halt,
  input wire [`EV_N-1:0] ev_limit,
  input wire [`EV_N-1:0] ev_irq,
  input wire [`EV_N-1:0] ev_dma,
  // status
  input wire [`CNT_W-1:0] count_val,
  input wire [`ST_W-1:0] state_val,
  input wire [`EV_N-1:0] ev_fired,
  input wire irq_req,
  input wire dma_req,
  input wire run_l,
  input wire dir_down_l
);
  reg [`ST_W-1:0] prev_state_reg;
  wire [`EV_N-1:0] state_ok;
  wire lim_uni;
  genvar gi;

  // state seen in the cycle an event fired
  always @(posedge ref_clk)
  begin
    prev_state_reg <= state_val;
  end

  // per event enable in that state
  generate
    for (gi = 0; gi < `EV_N; gi = gi + 1)
    begin : g_ok
      assign state_ok[gi] = (prev_state_reg < `ST_N) ?
        ev_state_mask[gi*`ST_N + prev_state_reg] : 1'b0;
    end
  endgenerate

  // split low half, up only, match reg 0 as limit
  assign lim_uni = !unify && auto_limit_l && !cap_mode[0] && !bidir_l;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_irq_cause: assert property (irq_req == |(ev_fired & ev_irq))
    else $error("interrupt pulse does not follow enabled events");
  a_dma_cause: assert property (dma_req == |(ev_fired & ev_dma))
    else $error("dma pulse does not follow enabled events");
  a_fired_in_state: assert property ((ev_fired & ~state_ok) == 10'h000)
    else $error("event fired outside its states");
  a_state_range: assert property (state_val < `ST_N)
    else $error("state outside the ten states");
  a_up_only_dir: assert property (!bidir_l |-> !dir_down_l)
    else $error("up only counter shows down direction");
  a_limit_bound: assert property (lim_uni |-> count_val[15:0] <= match_val[15:0])
    else $error("count passed the automatic limit");
  a_limit_clears: assert property (lim_uni && run_l && !clk_mode &&
    count_val[15:0] == match_val[15:0] |=> count_val[15:0] == 16'h0000)
    else $error("limit did not clear the counter");
  a_bidir_top_turn: assert property (!unify && bidir_l && auto_limit_l &&
    !cap_mode[0] && run_l && !clk_mode && !dir_down_l &&
    count_val[15:0] == match_val[15:0] |=> dir_down_l)
    else $error("limit did not reverse the counter");
  a_bidir_zero_turn: assert property (!unify && bidir_l && run_l && !clk_mode &&
    dir_down_l && count_val[15:0] == 16'h0000 |=> !dir_down_l ##0 count_val[15:0] == 16'h0000)
    else $error("counter did not turn up at zero");
  a_unified_step: assert property (unify && !bidir_l && !clk_mode && run_l &&
    !auto_limit_l && ev_limit == 10'h000 && ev_halt == 10'h000 && ev_stop == 10'h000
    |=> count_val == $past(count_val) + 32'h00000001)
    else $error("unified counter did not step by one");
endmodule // event_timer_monitor

bind event_state_timer_pwm event_timer_monitor u_monitor (.ref_clk, .rst_b, .unify,
  .bidir_l, .auto_limit_l, .clk_mode, .cap_mode, .match_val, .ev_state_mask, .ev_stop,
  .ev_halt, .ev_limit, .ev_irq, .ev_dma, .count_val, .state_val, .ev_fired, .irq_req,
  .dma_req, .run_l, .dir_down_l);

// File: dv/event_state_timer_pwm_test.sv
/*
  self checking bench of the event timer: pwm, io events, state, clocking.
  assumes the pin model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`include "event_timer_defines.vh"

module event_state_timer_pwm_test;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  wire [`IN_N-1:0] in_pins;
  wire [`OUT_N-1:0] out_pins;
  logic unify, bidir_l, bidir_h, auto_limit_l, auto_limit_h, clk_mode, clk_edge;
  logic halt_release_l, halt_release_h;
  logic [2:0] clk_in_sel;
  logic [`MR_N*`CNT_W-1:0] match_val;
  logic [`MR_N-1:0] cap_mode;
  logic [`EV_N*`ST_N-1:0] ev_state_mask;
  logic [`EV_N*`SEL_W-1:0] ev_match_sel, ev_io_sel;
  logic [`EV_N*`COND_W-1:0] ev_io_cond;
  logic [`EV_N*`COMB_W-1:0] ev_comb;
  logic [`EV_N*`DIRQ_W-1:0] ev_dir;
  logic [`EV_N-1:0] ev_ctr_h, ev_hold, ev_start, ev_stop, ev_halt, ev_limit;
  logic [`EV_N-1:0] ev_state_ld, ev_irq, ev_dma;
  logic [`EV_N*`OUT_N-1:0] ev_out_set, ev_out_clr;
  logic [`EV_N*`MR_N-1:0] ev_cap;
  logic [`EV_N*`ST_W-1:0] ev_next_state;
  wire [`CNT_W-1:0] count_val;
  wire [`MR_N*`CNT_W-1:0] cap_val;
  wire [`ST_W-1:0] state_val;
  wire [`EV_N-1:0] ev_fired;
  wire irq_req, dma_req, run_l, run_h, dir_down_l, dir_down_h;
  integer err_count = 0;
  integer check_count = 0;
  integer cyc = 0;

  // ----------------------------------------
  // clock, timeout, instances
  // ----------------------------------------
  always #50 ref_clk = ~ref_clk;

  // cut a hang short
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      err_count = err_count + 1;
      stop_test;
    end
  end

  input_pins_model u_pins (.ref_clk(ref_clk), .pins(in_pins));

  event_state_timer_pwm u_dut (.ref_clk, .rst_b, .in_pins, .out_pins, .unify, .bidir_l,
    .bidir_h, .auto_limit_l, .auto_limit_h, .clk_mode, .clk_in_sel, .clk_edge,
    .halt_release_l, .halt_release_h, .match_val, .cap_mode, .ev_state_mask,
    .ev_match_sel, .ev_io_sel, .ev_io_cond, .ev_comb, .ev_dir, .ev_ctr_h, .ev_hold,
    .ev_start, .ev_stop, .ev_halt, .ev_limit, .ev_out_set, .ev_out_clr, .ev_cap,
    .ev_next_state, .ev_state_ld, .ev_irq, .ev_dma, .count_val, .cap_val, .state_val,
    .ev_fired, .irq_req, .dma_req, .run_l, .run_h, .dir_down_l, .dir_down_h);

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task step(input integer n);
    repeat (n)
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // reset held while config changes, pins idle, no match selected
  task cfg_clear;
    rst_b = 1'b0;
    u_pins.pins_reg = '0;
    {unify, bidir_l, bidir_h, auto_limit_l, auto_limit_h, clk_mode, clk_edge} = '0;
    {halt_release_l, halt_release_h, clk_in_sel, match_val, cap_mode} = '0;
    {ev_state_mask, ev_io_sel, ev_io_cond, ev_comb, ev_dir, ev_cap, ev_next_state} = '0;
    {ev_ctr_h, ev_hold, ev_start, ev_stop, ev_halt, ev_limit, ev_state_ld} = '0;
    {ev_irq, ev_dma, ev_out_set, ev_out_clr} = '0;
    ev_match_sel = {`EV_N{4'hf}};
  endtask

  task ev_cfg(input integer i, input logic [3:0] msel, input logic [3:0] iosel,
    input logic [1:0] cond, input logic [1:0] comb, input logic [9:0] mask);
    ev_match_sel[i*4+:4] = msel;
    ev_io_sel[i*4+:4] = iosel;
    ev_io_cond[i*2+:2] = cond;
    ev_comb[i*2+:2] = comb;
    ev_state_mask[i*10+:10] = mask;
  endtask

  // reset with config applied, then a halt release pulse
  task reset_run;
    rst_b = 1'b0;
    step(3);
    rst_b = 1'b1;
    halt_release_l = 1'b1;
    step(1);
    halt_release_l = 1'b0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // period of 5 from match reg 0, out1 pwm, out0 toggle
  task test_pwm;
    cfg_clear;
    auto_limit_l = 1'b1;
    match_val[31:0] = 32'h00000004;
    match_val[63:32] = 32'h00000002;
    ev_cfg(0, 4'h0, 4'h0, `COND_LOW, `COMB_MATCH, 10'h001);
    ev_cfg(1, 4'h1, 4'h0, `COND_LOW, `COMB_MATCH, 10'h001);
    {ev_out_set[1], ev_out_set[0], ev_out_clr[0], ev_irq[0], ev_dma[0]} = 5'h1f;
    ev_out_clr[9] = 1'b1;
    reset_run;
    step(5);
    chk("wrap count", 32'h0, {16'h0, count_val[15:0]});
    chk("period start outs", 32'h3, {30'h0, out_pins[1:0]});
    chk("irq", 32'h1, {31'h0, irq_req});
    chk("dma", 32'h1, {31'h0, dma_req});
    step(3);
    chk("duty end outs", 32'h1, {30'h0, out_pins[1:0]});
    step(2);
    chk("next period outs", 32'h2, {30'h0, out_pins[1:0]});
  endtask

  // unified count, io edges and levels, capture, state, held match
  task test_io_state;
    cfg_clear;
    unify = 1'b1;
    cap_mode[6:5] = 2'h3;
    match_val[95:64] = 32'h0000000c;
    match_val[127:96] = 32'h00000008;
    ev_cfg(2, 4'hf, 4'h3, `COND_RISE, `COMB_IO, 10'h001);
    ev_cfg(3, 4'hf, 4'h3, `COND_FALL, `COMB_IO, 10'h001);
    ev_cfg(4, 4'h2, 4'h4, `COND_HIGH, `COMB_AND, 10'h009);
    ev_cfg(5, 4'h3, 4'h0, `COND_LOW, `COMB_MATCH, 10'h001);
    ev_cfg(6, 4'hf, 4'h5, `COND_HIGH, `COMB_IO, 10'h008);
    ev_cfg(7, 4'hf, 4'h5, `COND_LOW, `COMB_IO, 10'h001);
    {ev_cap[25], ev_cap[36], ev_hold[4], ev_state_ld[5]} = 4'hf;
    {ev_out_set[34], ev_out_set[51], ev_out_set[61]} = 3'h7;
    ev_next_state[23:20] = 4'h3;
    reset_run;
    step(2);
    u_pins.set_pin(5, 1'b1);
    step(2);
    chk("low level event out", 32'h1, {31'h0, out_pins[5]});
    chk("other state out", 32'h0, {31'h0, out_pins[3]});
    u_pins.set_pin(3, 1'b1);
    step(2);
    chk("rise capture", 32'h4, cap_val[5*32+:32]);
    u_pins.set_pin(3, 1'b0);
    step(2);
    chk("fall capture", 32'h6, cap_val[6*32+:32]);
    step(3);
    chk("state load", 32'h3, {28'h0, state_val});
    chk("new state out", 32'h1, {31'h0, out_pins[3]});
    step(3);
    chk("held match waits", 32'h0, {31'h0, out_pins[2]});
    u_pins.set_pin(4, 1'b1);
    step(2);
    chk("held match acts", 32'h1, {31'h0, out_pins[2]});
  endtask

  // counter clocked by input 0 edges, halted by an event
  task test_clock_halt;
    cfg_clear;
    clk_mode = 1'b1;
    ev_cfg(0, 4'hf, 4'h6, `COND_HIGH, `COMB_IO, 10'h001);
    ev_cfg(1, 4'hf, 4'h7, `COND_RISE, `COMB_IO, 10'h001);
    ev_cfg(2, 4'hf, 4'h5, `COND_RISE, `COMB_IO, 10'h001);
    {ev_halt[0], ev_start[1], ev_stop[2]} = 3'h7;
    reset_run;
    u_pins.pulse(0, 5);
    step(2);
    chk("input clocked count", 32'h5, {16'h0, count_val[15:0]});
    u_pins.set_pin(5, 1'b1);
    step(2);
    chk("stopped run", 32'h0, {31'h0, run_l});
    u_pins.set_pin(7, 1'b1);
    step(2);
    chk("restarted run", 32'h1, {31'h0, run_l});
    u_pins.set_pin(7, 1'b0);
    u_pins.set_pin(6, 1'b1);
    step(2);
    chk("halted run", 32'h0, {31'h0, run_l});
    u_pins.pulse(0, 2);
    chk("halted count", 32'h5, {16'h0, count_val[15:0]});
    u_pins.set_pin(6, 1'b0);
    u_pins.set_pin(7, 1'b1);
    step(2);
    chk("start while halted", 32'h0, {31'h0, run_l});
  endtask

  // up/down counter, event only on the down pass through 2
  task test_bidir;
    integer k, tog;
    logic [15:0] pc;
    logic pd, po;
    cfg_clear;
    {bidir_l, auto_limit_l} = 2'h3;
    match_val[31:0] = 32'h00000003;
    match_val[63:32] = 32'h00000002;
    ev_cfg(0, 4'h1, 4'h0, `COND_LOW, `COMB_MATCH, 10'h001);
    ev_dir[1:0] = `DIRQ_DOWN;
    {ev_out_set[4], ev_out_clr[4]} = 2'h3;
    reset_run;
    tog = 0;
    for (k = 0; k < 30; k = k + 1)
    begin
      {pc, pd, po} = {count_val[15:0], dir_down_l, out_pins[4]};
      step(1);
      if (out_pins[4] !== po)
      begin
        tog = tog + 1;
        chk("down only toggle", 32'h1, {31'h0, pc == 16'h2 && pd});
      end
    end
    chk("down toggles seen", 32'h1, {31'h0, tog >= 2});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    cfg_clear;
    test_pwm;
    test_io_state;
    test_clock_halt;
    test_bidir;
    stop_test;
  end
endmodule // event_state_timer_pwm_test
